/* File: verilog/single_wire_echo_uart.sv */
// Single-wire echo UART: receives a character on the shared pin, then drives
// the same character back on that pin, timed by an interval timer.
// Assumes line_i is synchronous to clock_i and the far end leaves the wire
// alone while an echo frame is out.
`timescale 1ns/1ps
module single_wire_echo_uart (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Shared line pin
    input wire logic line_i,
    output logic line_o,
    output logic line_oe_o,
    // Configuration
    input wire logic data7_i,
    input wire echo_uart_pkg::parity_e parity_i,
    input wire logic [echo_uart_pkg::TMR_W-1:0] baud_reload_i,
    // Character read port
    input wire logic read_i,
    output logic [echo_uart_pkg::DATA_W-1:0] char_o,
    output logic [echo_uart_pkg::STAT_W-1:0] status_o,
    // Status
    output logic rx_pending_o,
    output logic rx_enable_o,
    output logic rx_done_o,
    output logic busy_o
);
    import echo_uart_pkg::*;

    typedef struct packed {
        state_e st;
        logic [TMR_W-1:0] cnt;
        logic [3:0] bit_idx;
        logic [DATA_W-1:0] rx_sh;
        logic rx_par;
        logic prev_line;
        logic [DATA_W-1:0] rx_char_hold;
        logic [STAT_W-1:0] stat;
        logic [DATA_W-1:0] rd_char;
        logic [STAT_W-1:0] rd_stat;
        logic [15:0] tx_frame_word;
        logic [3:0] bits_remaining;
        logic line_out;
        logic line_oe;
        logic rx_en;
        logic done;
        logic busy;
        logic push_v;
        logic [DATA_W-1:0] push_d;
        logic tmr_start;
        logic tmr_stop;
    } core_s;

    core_s q;
    core_s d;
    echo_link_if link();

    // Data length of a character in bits
    function automatic logic [3:0] data_len(input logic seven);
        return seven ? DLEN_7 : DLEN_8;
    endfunction

    // Parity over the data bits only
    function automatic logic calc_parity(input logic [DATA_W-1:0] data, input logic seven,
                                         input parity_e pm);
        logic p;
        p = seven ? ^data[MSB_IDX-1:0] : ^data;
        return (pm == PAR_ODD) ? ~p : p;
    endfunction

    // Build the LSB-first frame, start bit at bit 0, stop and fill ones above
    function automatic logic [15:0] frame_build_step(input logic [DATA_W-1:0] data,
                                                     input logic seven, input parity_e pm);
        logic [DATA_W-1:0] dbits;
        logic [15:0] w;
        dbits = seven ? {1'b1, data[MSB_IDX-1:0]} : data;
        w = {FRAME_FILL, dbits};
        w = {w[14:0], 1'b0};
        if (pm != PAR_NONE) begin
            w[data_len(seven) + 4'h1] = calc_parity(data, seven, pm);
        end
        return w;
    endfunction

    // Character FIFO and bit timer
    echo_char_fifo #(
        .W(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .link(link.fifo)
    );

    echo_bit_timer u_timer (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .link(link.timer)
    );

    // Core-side drive of the carrier
    assign link.push_valid = q.push_v;
    assign link.push_data = q.push_d;
    assign link.tmr_start = q.tmr_start;
    assign link.tmr_stop = q.tmr_stop;
    assign link.tmr_reload = baud_reload_i;
    // Echo only from an idle receiver, so a frame never cuts into a reception
    assign link.pop_ready = (q.st == ST_RX_IDLE);

    // Outputs come straight from the state register
    assign line_o = q.line_out;
    assign line_oe_o = q.line_oe;
    assign char_o = q.rd_char;
    assign status_o = q.rd_stat;
    assign rx_pending_o = q.stat[STAT_VALID];
    assign rx_enable_o = q.rx_en;
    assign rx_done_o = q.done;
    assign busy_o = q.busy;

    // Sequencer: receive, echo, release
    always_comb begin
        d = q;
        d.done = 1'b0;
        d.push_v = 1'b0;
        d.tmr_start = 1'b0;
        d.tmr_stop = 1'b0;
        d.prev_line = line_i;
        // Read hands out character and status, then status clears
        if (read_i) begin
            d.rd_char = q.rx_char_hold;
            d.rd_stat = q.stat;
            d.stat = '0;
        end
        case (q.st)
            ST_RX_IDLE: begin
                if (link.pop_valid) begin
                    // Pending character leaves at once as an echo
                    d.tx_frame_word = frame_build_step(link.pop_data, data7_i, parity_i);
                    d.bits_remaining = FRAME_BASE + data_len(data7_i)
                                       + 4'(parity_i != PAR_NONE);
                    d.rx_en = 1'b0;
                    d.busy = 1'b1;
                    d.st = ST_TX_PREP;
                end else if (q.rx_en && q.prev_line && !line_i) begin
                    // Falling edge, check the start bit at mid period
                    d.cnt = {1'b0, baud_reload_i[TMR_W-1:1]};
                    d.st = ST_RX_START;
                end
            end
            ST_RX_START: begin
                if (q.cnt == '0) begin
                    d.cnt = baud_reload_i;
                    d.bit_idx = '0;
                    d.st = line_i ? ST_RX_IDLE : ST_RX_BITS; // Glitch returns to idle
                end else begin
                    d.cnt = q.cnt - 1'b1;
                end
            end
            ST_RX_BITS: begin
                if (q.cnt == '0) begin
                    d.cnt = baud_reload_i;
                    d.rx_sh[q.bit_idx[2:0]] = line_i;
                    d.bit_idx = q.bit_idx + 4'h1;
                    if (q.bit_idx == data_len(data7_i) - 4'h1) begin
                        d.st = (parity_i == PAR_NONE) ? ST_RX_STOP : ST_RX_PAR;
                    end
                end else begin
                    d.cnt = q.cnt - 1'b1;
                end
            end
            ST_RX_PAR: begin
                if (q.cnt == '0) begin
                    d.cnt = baud_reload_i;
                    d.rx_par = line_i;
                    d.st = ST_RX_STOP;
                end else begin
                    d.cnt = q.cnt - 1'b1;
                end
            end
            ST_RX_STOP: begin
                if (q.cnt == '0) begin
                    // Capture beats a same-cycle read clear
                    d.rx_char_hold = data7_i ? {1'b0, q.rx_sh[MSB_IDX-1:0]}
                                             : q.rx_sh;
                    d.stat[STAT_VALID] = 1'b1;
                    d.stat[STAT_PERR] = (parity_i != PAR_NONE) &&
                        (calc_parity(q.rx_sh, data7_i, parity_i) != q.rx_par);
                    d.stat[STAT_FERR] = !line_i;
                    d.stat[STAT_OVR] = !link.push_ready;
                    d.push_v = link.push_ready;
                    d.push_d = data7_i ? {1'b0, q.rx_sh[MSB_IDX-1:0]} : q.rx_sh;
                    d.done = 1'b1;
                    d.st = ST_RX_IDLE;
                end else begin
                    d.cnt = q.cnt - 1'b1;
                end
            end
            ST_TX_PREP: begin
                // Receiver already off; take the pin at idle high, then start timer
                d.line_oe = 1'b1;
                d.line_out = 1'b1;
                d.tmr_start = 1'b1;
                d.st = ST_TX_SHIFT;
            end
            ST_TX_SHIFT: begin
                // A tick is served in the cycle it arrives, nothing waits ahead of it
                if (link.tmr_tick) begin
                    if (q.bits_remaining != 4'h0) begin
                        d.line_out = q.tx_frame_word[0];
                        d.tx_frame_word = {1'b1, q.tx_frame_word[15:1]};
                        d.bits_remaining = q.bits_remaining - 4'h1;
                    end else begin
                        // Stop bit has had its full period
                        d.tmr_stop = 1'b1;
                        d.line_oe = 1'b0;
                        d.st = ST_TX_RELEASE;
                    end
                end
            end
            ST_TX_RELEASE: begin
                // Pin released a cycle earlier, now listen again
                d.rx_en = 1'b1;
                d.busy = 1'b0;
                d.st = ST_RX_IDLE;
            end
            default: begin
                d.st = ST_RX_IDLE;
                d.line_oe = 1'b0;
                d.rx_en = 1'b1;
            end
        endcase
    end

    // State register; line idles high and receiver starts enabled
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0;
            q.st <= ST_RX_IDLE;
            q.line_out <= 1'b1;
            q.prev_line <= 1'b1;
            q.rx_en <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Helpers for the shift and frame checks
    logic frame_lsb;
    logic end_tick;
    logic [15:0] par_span;
    assign frame_lsb = q.tx_frame_word[0];
    // Bits from the first data bit through the parity position
    assign par_span = (16'h0001 << (data_len(data7_i) + 4'h2)) - 16'h0002;
    assign end_tick = (q.st == ST_TX_SHIFT) && link.tmr_tick && (q.bits_remaining == 4'h0);

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    a_pin_only_tx: assert property (line_oe_o |-> q.st == ST_TX_SHIFT)
        else $error("pin driven outside a transmit frame");
    a_rx_off_tx: assert property (line_oe_o |-> !rx_enable_o)
        else $error("receiver active while pin driven");
    a_timer_after_pin: assert property (
        link.tmr_start |-> line_oe_o && !rx_enable_o ##1 link.tmr_run)
        else $error("timer started before pin turned to output");
    a_shift_one_bit: assert property (
        (q.st == ST_TX_SHIFT) && link.tmr_tick && (q.bits_remaining != 4'h0)
        |=> line_o == $past(frame_lsb) && q.bits_remaining == $past(q.bits_remaining) - 4'h1)
        else $error("tick did not shift out exactly one bit");
    a_end_release: assert property (
        end_tick |=> !line_oe_o && link.tmr_stop && !rx_enable_o ##1 !link.tmr_run && rx_enable_o)
        else $error("frame end did not stop timer and restart receiver in order");
    a_frame_start: assert property (
        $rose(line_oe_o) |-> !frame_lsb && line_o && q.tx_frame_word[15])
        else $error("frame word lacks start bit or fill");
    a_frame_len: assert property (
        $rose(line_oe_o) |-> q.bits_remaining >= FRAME_MIN && q.bits_remaining <= FRAME_MAX)
        else $error("frame length out of range");
    a_status_clear: assert property (
        read_i && (q.st != ST_RX_STOP) |=> !rx_pending_o && status_o == $past(q.stat))
        else $error("read did not return and clear status");
    a_seven_mask: assert property (rx_done_o && data7_i |-> !q.rx_char_hold[MSB_IDX])
        else $error("eighth bit kept in seven-bit mode");
    a_echo_follows: assert property (
        rx_done_o && link.push_valid |-> ##[1:4] busy_o)
        else $error("received character not echoed");

    // Capture raises the pending flag in the same cycle as the done pulse
    a_done_pending: assert property (rx_done_o |-> rx_pending_o)
        else $error("done pulse without pending character");

    // A stretched pulse would look like a second character to a counter
    a_done_single: assert property (rx_done_o |=> !rx_done_o)
        else $error("done pulse longer than one cycle");

    // Receiver is off for the whole echo, so the held character is the one going out
    a_echo_value: assert property (
        $rose(line_oe_o) |-> q.tx_frame_word[MSB_IDX:1] == q.rx_char_hold[MSB_IDX-1:0]
        && (data7_i || q.tx_frame_word[MSB_IDX+1] == q.rx_char_hold[MSB_IDX]))
        else $error("echo frame carries another character");

    // Data bits plus parity bit must add up to the selected sense
    a_parity_place: assert property (
        $rose(line_oe_o) && (parity_i != PAR_NONE)
        |-> (^(q.tx_frame_word & par_span)) == (parity_i == PAR_ODD))
        else $error("parity bit misplaced or wrong");

    c_rx_done: cover property (rx_done_o);
    c_tx_end: cover property (end_tick);
    c_parity_err: cover property (rx_done_o && q.stat[STAT_PERR]);
    c_seven_frame: cover property ($rose(line_oe_o) && data7_i);
endmodule

/* File: verilog/echo_uart_pkg.sv */
// Constants, enumerations and field layouts of the single-wire echo UART.
// Assumes one system clock shared by the receiver and the bit timer.
package echo_uart_pkg;

    // Clock and line rate that the default timer reload is derived from
    localparam int unsigned SYS_CLK_HZ = 20_000_000;
    localparam int unsigned BAUD_DEFAULT = 76_800;
    localparam logic [15:0] RELOAD_DEFAULT = 16'(SYS_CLK_HZ / BAUD_DEFAULT - 1);

    // Widths and depths
    localparam int unsigned DATA_W = 8;
    localparam int unsigned FIFO_DEPTH = 4;
    localparam int unsigned TMR_W = 16;

    // Frame layout
    localparam logic [7:0] FRAME_FILL = 8'hff;
    localparam logic [3:0] DLEN_8 = 4'h8;
    localparam logic [3:0] DLEN_7 = 4'h7;
    localparam logic [3:0] FRAME_BASE = 4'h2;
    localparam logic [3:0] FRAME_MIN = 4'h9;
    localparam logic [3:0] FRAME_MAX = 4'hb;
    localparam int unsigned MSB_IDX = 7;

    // Reception status fields
    localparam int unsigned STAT_W = 4;
    localparam int unsigned STAT_PERR = 0;
    localparam int unsigned STAT_FERR = 1;
    localparam int unsigned STAT_OVR = 2;
    localparam int unsigned STAT_VALID = 3;

    // Parity selection, even is the power-on choice
    typedef enum logic [1:0] {
        PAR_EVEN = 2'b00,
        PAR_ODD = 2'b01,
        PAR_NONE = 2'b10
    } parity_e;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_RX_IDLE = 3'b000,
        ST_RX_START = 3'b001,
        ST_RX_BITS = 3'b010,
        ST_RX_PAR = 3'b011,
        ST_RX_STOP = 3'b100,
        ST_TX_PREP = 3'b101,
        ST_TX_SHIFT = 3'b110,
        ST_TX_RELEASE = 3'b111
    } state_e;

endpackage

/* File: verilog/echo_link_if.sv */
// Carrier between the echo core, its character FIFO and its bit timer.
// Assumes all three parties run on the same clock.
`timescale 1ns/1ps
interface echo_link_if;
    import echo_uart_pkg::*;
    // Character stream into and out of the FIFO
    logic push_valid;
    logic push_ready;
    logic [DATA_W-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [DATA_W-1:0] pop_data;
    // Bit timer control and ticks
    logic tmr_start;
    logic tmr_stop;
    logic [TMR_W-1:0] tmr_reload;
    logic tmr_tick;
    logic tmr_run;

    modport core (output push_valid, push_data, pop_ready, tmr_start, tmr_stop, tmr_reload,
                  input push_ready, pop_valid, pop_data, tmr_tick, tmr_run);
    modport fifo (input push_valid, push_data, pop_ready,
                  output push_ready, pop_valid, pop_data);
    modport timer (input tmr_start, tmr_stop, tmr_reload, output tmr_tick, tmr_run);
endinterface

/* File: verilog/echo_char_fifo.sv */
// Small flip-flop FIFO holding received characters until they are echoed.
// Assumes DEPTH is a power of two so the pointers wrap by themselves.
`timescale 1ns/1ps
module echo_char_fifo #(
    parameter int unsigned W = 8,
    parameter int unsigned DEPTH = 4
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Stream ports
    echo_link_if.fifo link
);
    import echo_uart_pkg::*;

    localparam int unsigned AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } fifo_s;

    fifo_s q;
    fifo_s d;
    logic do_push;
    logic do_pop;

    // Honest flags straight from the occupancy count
    assign link.push_ready = (q.cnt != FULL_CNT);
    assign link.pop_valid = (q.cnt != '0);
    assign link.pop_data = q.mem[q.rd];

    // Next state of storage and pointers
    always_comb begin
        d = q;
        do_push = link.push_valid && link.push_ready;
        do_pop = link.pop_valid && link.pop_ready;
        if (do_push) begin
            d.mem[q.wr] = link.push_data;
            d.wr = q.wr + 1'b1;
        end
        if (do_pop) begin
            d.rd = q.rd + 1'b1;
        end
        d.cnt = q.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end

    // State register
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // A refused push must leave the write pointer where it was
    a_fifo_full_refuse: assert property (!link.push_ready |=> q.wr == $past(q.wr))
        else $error("fifo stored a word while full");
endmodule

/* File: verilog/echo_bit_timer.sv */
// Repeating interval timer giving one tick per bit period.
// Assumes start and stop are one-cycle pulses from the core.
`timescale 1ns/1ps
module echo_bit_timer (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Timer control and ticks
    echo_link_if.timer link
);
    import echo_uart_pkg::*;

    typedef struct packed {
        logic run;
        logic tick;
        logic [TMR_W-1:0] cnt;
    } tmr_s;

    tmr_s q;
    tmr_s d;
    logic [TMR_W-1:0] gap_q;
    logic seen_q;

    // Ticks stay internal, no pin is toggled
    assign link.tmr_tick = q.tick;
    assign link.tmr_run = q.run;

    // Started only by the core's internal pulse, reloads on each tick
    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (link.tmr_stop) begin
            d.run = 1'b0;
        end else if (link.tmr_start) begin
            d.run = 1'b1;
            d.cnt = link.tmr_reload;
        end else if (q.run) begin
            if (q.cnt == '0) begin
                d.tick = 1'b1;
                d.cnt = link.tmr_reload; // Period is reload plus one
            end else begin
                d.cnt = q.cnt - 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Cycles since the previous tick, only for checking
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            gap_q <= '0;
            seen_q <= 1'b0;
        end else begin
            gap_q <= q.tick ? '0 : gap_q + 1'b1;
            seen_q <= q.run && (seen_q || q.tick);
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    a_tick_period: assert property (
        q.tick && seen_q && $stable(link.tmr_reload) |-> gap_q == link.tmr_reload)
        else $error("bit tick spacing differs from reload plus one");
    a_no_tick_idle: assert property (!q.run |=> !q.tick)
        else $error("tick while timer stopped");
endmodule

/* File: tb/remote_uart_model.sv */
// Remote UART peer on the shared wire: sends frames and captures echoes.
// Assumes a pull-up on the wire, so a released line reads high.
`timescale 1ns/1ps
module remote_uart_model (
    // Clock and wire
    input wire logic clock_i,
    input wire logic wire_i,
    // Remote drive, high when released
    output logic drive_o
);
    int period = 16;

    // Released wire sits at the pull-up level
    initial begin
        drive_o = 1'b1;
    end

    // Whole frame, one bit per period, LSB first
    task automatic send(input logic [10:0] frame, input int nbits);
        for (int i = 0; i < nbits; i++) begin
            drive_o = frame[i];
            repeat (period) @(negedge clock_i);
        end
        drive_o = 1'b1;
    endtask

    // Mid-bit sampling of the echo; bounded wait for the start bit
    task automatic get_echo(input int nbits, output logic [10:0] frame, output logic ok);
        int n;
        frame = '1; // Unsampled positions read as idle ones
        ok = 1'b0;
        n = 0;
        while (wire_i !== 1'b0 && n < 4000) begin
            @(negedge clock_i);
            n++;
        end
        if (n < 4000) begin
            ok = 1'b1;
            repeat (period / 2) @(negedge clock_i);
            for (int i = 0; i < nbits; i++) begin
                frame[i] = wire_i;
                if (i < nbits - 1) begin
                    repeat (period) @(negedge clock_i);
                end
            end
        end
    endtask
endmodule

/* File: tb/test_single_wire_echo_uart.sv */
// Self-checking bench for the single-wire echo UART with a remote peer model.
// Assumes a short bit period (reload 15) to keep the run brief, plus one run at the default rate.
`timescale 1ns/1ps
module test_single_wire_echo_uart;
    import echo_uart_pkg::*;
    localparam logic [15:0] RELOAD = 16'h000f;
    logic [15:0] reload = RELOAD;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic data7 = 1'b0;
    logic read = 1'b0;
    parity_e parity = PAR_EVEN;
    logic line_i, line_o, line_oe_o, rx_pending, rx_enable, rx_done, busy, remote_drv;
    logic [DATA_W-1:0] char_o;
    logic [STAT_W-1:0] status_o;
    int bad_count = 0;
    int tests_run = 0;
    int done_cnt = 0;

    always #5 clock_i = ~clock_i;
    // Wire level from the UART's enable: its drive while enabled, else the remote drive
    assign line_i = line_oe_o ? line_o : remote_drv;
    // Count reception-complete pulses at the falling edge, where they are settled
    always @(negedge clock_i) begin
        if (rx_done === 1'b1) begin
            done_cnt++;
        end
    end

    single_wire_echo_uart i_single_wire_echo_uart (.clock_i(clock_i), .rst_i(rst_i),
        .line_i(line_i), .line_o(line_o), .line_oe_o(line_oe_o), .data7_i(data7),
        .parity_i(parity), .baud_reload_i(reload), .read_i(read), .char_o(char_o),
        .status_o(status_o), .rx_pending_o(rx_pending), .rx_enable_o(rx_enable),
        .rx_done_o(rx_done), .busy_o(busy));
    remote_uart_model i_remote_uart_model (.clock_i(clock_i), .wire_i(line_i),
        .drive_o(remote_drv));

    // Start 0, data LSB first, parity after last data, then stop
    function automatic logic [10:0] make_frame(logic [7:0] c, logic seven, parity_e p,
                                               logic stop);
        logic [10:0] f;
        int n;
        logic [7:0] mask;
        f = 11'h7ff;
        n = seven ? 7 : 8;
        mask = seven ? 8'h7f : 8'hff;
        f[0] = 1'b0;
        for (int i = 0; i < n; i++) f[i+1] = c[i];
        if (p != PAR_NONE) begin
            f[n+1] = (p == PAR_ODD) ? ~^(c & mask) : ^(c & mask);
            n++;
        end
        f[n+1] = stop;
        return f;
    endfunction

    task automatic test_done();
        $display("tests %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check_val(input logic [10:0] got, input logic [10:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Bounded wait until the receiver listens again
    task automatic wait_idle();
        int n;
        n = 0;
        while (rx_enable !== 1'b1 && n < 5000) begin
            @(negedge clock_i);
            n++;
        end
        if (n >= 5000) begin
            bad_count++;
            $display("[ERR] %0t receiver never re-enabled", $time);
            test_done();
        end
    endtask

    task automatic test_reset();
        check_val(line_oe_o, 1'b0, "oe after reset");
        check_val(line_o, 1'b1, "line idle");
        check_val(rx_enable, 1'b1, "rx on");
        check_val({busy, rx_pending}, 2'b00, "idle flags");
        $display("test reset done");
    endtask

    // One character out and its echo back, then read twice
    // A set perr flips the parity bit sent, the echo still carries good parity
    task automatic test_echo(input logic [7:0] c, input logic seven, input parity_e p,
                             input logic stop, input logic perr);
        logic [10:0] got;
        logic [10:0] tx;
        logic ok;
        int n;
        int d0;
        data7 = seven;
        parity = p;
        n = (seven ? 9 : 10) + ((p != PAR_NONE) ? 1 : 0);
        d0 = done_cnt;
        tx = make_frame(c, seven, p, stop) ^ (11'(perr) << (seven ? 8 : 9));
        @(negedge clock_i);
        i_remote_uart_model.send(tx, n);
        i_remote_uart_model.get_echo(n, got, ok);
        check_val(ok, 1'b1, "echo start");
        if (ok !== 1'b1) begin
            test_done();
        end
        check_val({rx_enable, line_oe_o, busy}, 3'b011, "tx mode");
        check_val(got, make_frame(c, seven, p, 1'b1), "echo frame");
        check_val(11'(done_cnt - d0), 11'h001, "done pulse");
        wait_idle();
        check_val(line_oe_o, 1'b0, "pin released");
        check_val(rx_pending, 1'b1, "pending");
        read = 1'b1;
        @(negedge clock_i);
        read = 1'b0;
        @(negedge clock_i);
        check_val(char_o, seven ? {1'b0, c[6:0]} : c, "char");
        check_val(status_o, {1'b1, 1'b0, ~stop, perr}, "status");
        check_val(rx_pending, 1'b0, "pending cleared");
        read = 1'b1;
        @(negedge clock_i);
        read = 1'b0;
        @(negedge clock_i);
        check_val(status_o, 4'h0, "status cleared");
        $display("test echo %h done", c);
    endtask

    // Main sequence: 12 cycles of reset, then every parity mode at 8 bits, and even and none at 7 bits
    initial begin
        repeat (12) @(negedge clock_i);
        rst_i = 1'b0;
        @(negedge clock_i);
        test_reset();
        test_echo(8'ha5, 1'b0, PAR_EVEN, 1'b1, 1'b0);
        test_echo(8'h3c, 1'b0, PAR_ODD, 1'b1, 1'b1);
        test_echo(8'h81, 1'b0, PAR_NONE, 1'b1, 1'b0);
        test_echo(8'hd3, 1'b1, PAR_EVEN, 1'b1, 1'b0);
        test_echo(8'hc4, 1'b1, PAR_NONE, 1'b1, 1'b0);
        test_echo(8'h5a, 1'b0, PAR_ODD, 1'b0, 1'b0);
        // Default rate: the peer times bits at 260 clocks, so a wrong period breaks the echo
        reload = RELOAD_DEFAULT;
        i_remote_uart_model.period = int'(RELOAD_DEFAULT) + 1;
        test_echo(8'h6e, 1'b0, PAR_EVEN, 1'b1, 1'b0);
        test_done();
    end
endmodule
